// *** logic/qpse_pkg.sv ***
// Constants, encodings and state layout of the four-port power sequencer.
// Assumes a 10 MHz system clock; slow timing is counted in 1 ms ticks.
package qpse_pkg;

   localparam int NPORT = 4;

   // Clock and derived cycle counts.
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_CLAMP_NS    = 10000;
   localparam int CLAMP_CYC     = (T_CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_TICK_NS     = 1000000;
   localparam int TICK_CYC      = T_TICK_NS / CLK_PERIOD_NS;

   // Sequence timing in 1 ms ticks.
   localparam logic [11:0] T_SETTLE_MS  = 12'h0014;
   localparam logic [11:0] T_MARK_MS    = 12'h000A;
   localparam logic [11:0] T_START_MS   = 12'h003C;
   localparam logic [11:0] T_DISC_MS    = 12'h015E;
   localparam logic [11:0] T_BACKOFF_MS = 12'h02EE;
   localparam logic [11:0] T_GAP_EP_MS  = 12'h0064;
   localparam logic [11:0] T_GAP_MID_MS = 12'h07D0;

   // Overload integrator: up by 15 while overloaded, down by 1 otherwise.
   localparam logic [9:0] OVL_UP    = 10'h00F;
   localparam logic [9:0] OVL_DN    = 10'h001;
   localparam logic [9:0] OVL_LIMIT = 10'h384;

   // Currents in 100 uA counts.
   localparam logic [15:0] I_LIM_400 = 16'h0FA0;
   localparam logic [15:0] I_LIM_800 = 16'h1F40;
   localparam logic [15:0] I_DISC    = 16'h004B;
   localparam logic [15:0] RANGE_UP  = 16'h01F4;
   localparam logic [15:0] RANGE_DN  = 16'h01C2;
   localparam logic [16:0] SIG_DMIN  = 17'h0_0001;
   localparam logic [16:0] SIG_DMAX  = 17'h0_0003;
   localparam int          FOLD_SHIFT = 2;

   // Register indices.
   localparam logic [3:0] REG_MODE   = 4'h0;
   localparam logic [3:0] REG_CFG    = 4'h1;
   localparam logic [3:0] REG_EVENT  = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_CUR0   = 4'h4;
   localparam logic [3:0] REG_VEE    = 4'h8;
   localparam logic [3:0] REG_CLS0   = 4'h9;

   // Field positions.
   localparam int MODE_AUTO   = 0;
   localparam int MODE_SLOPE  = 1;
   localparam int MODE_MIDSPAN = 2;
   localparam int CFG_HP0     = 0;
   localparam int CFG_LIM0    = 4;
   localparam int EV_DET      = 0;
   localparam int EV_CLS      = 1;
   localparam int EV_CUT      = 2;
   localparam int EV_DISC     = 3;
   localparam int EV_THERM    = 16;

   typedef enum logic [2:0] {
      FV_OFF = 3'h0, FV_4V = 3'h1, FV_8V = 3'h2, FV_18V = 3'h3, FV_MAIN = 3'h4
   } qpse_force_t;

   typedef enum logic [2:0] {
      IL_OFF = 3'h0, IL_3MA = 3'h1, IL_60MA = 3'h2, IL_7P5MA = 3'h3, IL_400 = 3'h4, IL_800 = 3'h5
   } qpse_ilim_t;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b00_0001,
      ST_DET     = 6'b00_0010,
      ST_CLS     = 6'b00_0100,
      ST_START   = 6'b00_1000,
      ST_ON      = 6'b01_0000,
      ST_BACKOFF = 6'b10_0000
   } qpse_state_t;

   typedef struct packed {
      qpse_state_t st;
      logic [1:0]  step;
      logic [11:0] ms;
      logic [15:0] i_a;
      logic [15:0] i_b;
      logic [9:0]  ovl;
      logic [6:0]  clamp;
      logic        lim_low;
      logic [15:0] cls;
      logic        range_hi;
   } qpse_port_t;

endpackage

// *** logic/qpse_seq.sv ***
// Four-port power sequencer: detection, classification, power-up, protection, disconnect.
// Assumes analog front end supplies raw measurements and comparator flags asynchronously.
//
// Behaviour
// - Detect at 4 V, 8 V, 4 V, 3 mA.
// - Signature valid only rising and falling compliant.
// - Good detection always starts classification.
// - Class probe at 18 V, 60 mA.
// - Standard power one event, high power two.
// - Current limit selectable 400 or 800 mA.
// - Short circuit cut at limit plus 25%.
// - Surge clamps gate at least 10 us.
// - Foldback scaled with programmed limit.
// - Slope mode drops limit to 7.5 mA.
// - Slope mode: no rise in 350 ms, off.
// - Current under 7.5 mA 350 ms, off.
// - Continuous current monitoring with range switching.
// - Thermal port shutdown reported as overload cut-off.
// - Over 120 C: all ports off, no detection.
// - Port current 16-bit, 100 uA per count.
// - Supply voltage 16-bit, 1 mV per count.
// - Reset into shutdown or autonomous by build.
// - Endpoint or midspan detection timing selectable.
// - Port voltage fault (port_vbad) treated as current limited.
// - Overload integrated by 15:1 up/down counter.
// - Overload over 60 ms after start cuts port.
// - Autonomous re-power after over 750 ms.
module qpse_seq #(
   parameter bit STARTUP_AUTO = 1'b1,
   parameter int TICK_CYCLES  = qpse_pkg::TICK_CYC
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   input  wire logic [3:0][15:0]    port_cur_raw,
   input  wire logic [15:0]         vee_raw,
   input  wire logic [3:0]          port_vrise,
   input  wire logic [3:0]          port_surge,
   input  wire logic [3:0]          port_hot,
   input  wire logic [3:0]          port_vbad,
   input  wire logic                die_hot,
   output logic [3:0][2:0]          port_force,
   output logic [3:0][2:0]          port_ilim,
   output logic [3:0]               port_gate_on,
   output logic [3:0]               port_clamp,
   output logic [3:0]               port_range_hi,
   output logic [3:0][15:0]         port_fold_ref
);
   import qpse_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      qpse_port_t [3:0]  p;
      logic [TW-1:0]     tick_cnt;
      logic [2:0]        mode;
      logic [7:0]        cfg;
      logic [16:0]       ev;
      logic [31:0]       rdata;
      logic [3:0][15:0]  cur1;
      logic [3:0][15:0]  cur2;
      logic [15:0]       vee1;
      logic [15:0]       vee2;
      logic [16:0]       flg1;
      logic [16:0]       flg2;
   } qpse_all_t;

   qpse_all_t st_reg;
   qpse_all_t st_next;

   // Programmed operating limit in 100 uA counts.
   function automatic logic [15:0] qpse_lim(input logic hi);
      return hi ? I_LIM_800 : I_LIM_400;
   endfunction

   // Compact status code of a port state.
   function automatic logic [2:0] qpse_code(input qpse_state_t s);
      case (s)
         ST_DET:     qpse_code = 3'h1;
         ST_CLS:     qpse_code = 3'h2;
         ST_START:   qpse_code = 3'h3;
         ST_ON:      qpse_code = 3'h4;
         ST_BACKOFF: qpse_code = 3'h5;
         default:    qpse_code = 3'h0;
      endcase
   endfunction

   // All next-state logic: synchronisers, register port, and the four port sequencers.
   always_comb begin
      logic        tick;
      logic        hot;
      logic [15:0] cur;
      logic [15:0] lim;
      logic [16:0] d_up;
      logic [16:0] d_dn;
      logic        hp;
      logic        powered;
      logic        ovl;
      logic        cls_done;
      logic [11:0] gap;
      tick = 1'b0;
      hot = 1'b0;
      cur = '0;
      lim = '0;
      d_up = '0;
      d_dn = '0;
      hp = 1'b0;
      powered = 1'b0;
      ovl = 1'b0;
      cls_done = 1'b0;
      gap = '0;
      st_next = st_reg;
      st_next.rdata = '0;

      // Two-stage synchronisers; only the second stage is used below.
      st_next.cur1 = port_cur_raw;
      st_next.cur2 = st_reg.cur1;
      st_next.vee1 = vee_raw;
      st_next.vee2 = st_reg.vee1;
      st_next.flg1 = {die_hot, port_vbad, port_hot, port_surge, port_vrise};
      st_next.flg2 = st_reg.flg1;

      // Millisecond tick enable.
      if (st_reg.tick_cnt == TW'(TICK_CYCLES - 1)) begin
         st_next.tick_cnt = '0;
         tick = 1'b1;
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + TW'(1);
      end
      hot = st_reg.flg2[16];
      gap = st_reg.mode[MODE_MIDSPAN] ? T_GAP_MID_MS : T_GAP_EP_MS;

      // Register writes; event clears come first so a same-cycle event set wins.
      if (reg_wr) begin
         case (reg_addr)
            REG_MODE:  st_next.mode = reg_wdata[2:0];
            REG_CFG:   st_next.cfg = reg_wdata[7:0];
            REG_EVENT: st_next.ev = st_reg.ev & ~reg_wdata[16:0];
            default:   ;
         endcase
      end

      // Register reads; data stand only in the following cycle.
      if (reg_rd) begin
         case (reg_addr)
            REG_MODE:   st_next.rdata = {29'h0, st_reg.mode};
            REG_CFG:    st_next.rdata = {24'h0, st_reg.cfg};
            REG_EVENT:  st_next.rdata = {15'h0, st_reg.ev};
            REG_STATUS: st_next.rdata = {15'h0, hot, 4'h0, qpse_code(st_reg.p[3].st),
                                         qpse_code(st_reg.p[2].st), qpse_code(st_reg.p[1].st),
                                         qpse_code(st_reg.p[0].st)};
            REG_VEE:    st_next.rdata = {16'h0, st_reg.vee2};
            default: begin
               if (reg_addr >= REG_CUR0 && reg_addr < REG_VEE) begin
                  st_next.rdata = {16'h0, st_reg.cur2[reg_addr[1:0]]};
               end else if (reg_addr >= REG_CLS0 && reg_addr <= REG_CLS0 + 4'h3) begin
                  st_next.rdata = {16'h0, st_reg.p[2'(reg_addr - REG_CLS0)].cls};
               end
            end
         endcase
      end

      // Global thermal shutdown flag.
      if (hot) begin
         st_next.ev[EV_THERM] = 1'b1;
      end

      // Independent sequencer for each port.
      for (int i = 0; i < NPORT; i++) begin
         cur = st_reg.cur2[i];
         hp = st_reg.cfg[CFG_HP0 + i];
         lim = qpse_lim(st_reg.cfg[CFG_LIM0 + i]);
         powered = (st_reg.p[i].st == ST_START) || (st_reg.p[i].st == ST_ON);
         ovl = (cur > lim) || st_reg.flg2[12 + i];
         cls_done = 1'b0;

         // Surge clamp is held a fixed minimum so the normal limiter can take over.
         if (st_reg.flg2[4 + i]) begin
            st_next.p[i].clamp = 7'(CLAMP_CYC);
         end else if (st_reg.p[i].clamp != 7'h0) begin
            st_next.p[i].clamp = st_reg.p[i].clamp - 7'h1;
         end

         // Measurement range with hysteresis so it does not chatter near the boundary.
         if (cur >= RANGE_UP) begin
            st_next.p[i].range_hi = 1'b1;
         end else if (cur < RANGE_DN) begin
            st_next.p[i].range_hi = 1'b0;
         end

         if (hot || !st_reg.mode[MODE_AUTO]) begin
            // Over-temperature or shutdown mode: everything off, detection held off.
            st_next.p[i].st = ST_IDLE;
            st_next.p[i].step = 2'h0;
            st_next.p[i].ms = '0;
            st_next.p[i].ovl = '0;
            st_next.p[i].lim_low = 1'b0;
         end else if (powered && ((cur > lim + (lim >> 2)) || st_reg.flg2[8 + i])) begin
            // Short circuit or an overheating port at any current: immediate cut.
            st_next.p[i].st = ST_BACKOFF;
            st_next.p[i].ms = '0;
            st_next.ev[4*i + EV_CUT] = 1'b1;
         end else begin
            case (st_reg.p[i].st)
               ST_IDLE: begin
                  if (tick) begin
                     if (st_reg.p[i].ms >= gap) begin
                        st_next.p[i].st = ST_DET;
                        st_next.p[i].step = 2'h0;
                        st_next.p[i].ms = '0;
                     end else begin
                        st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                     end
                  end
               end
               ST_DET: begin
                  if (tick && st_reg.p[i].ms == T_SETTLE_MS) begin
                     st_next.p[i].ms = '0;
                     case (st_reg.p[i].step)
                        2'h0: begin
                           st_next.p[i].i_a = cur;
                           st_next.p[i].step = 2'h1;
                        end
                        2'h1: begin
                           st_next.p[i].i_b = cur;
                           st_next.p[i].step = 2'h2;
                        end
                        default: begin
                           d_up = {1'b0, st_reg.p[i].i_b} - {1'b0, st_reg.p[i].i_a};
                           d_dn = {1'b0, st_reg.p[i].i_b} - {1'b0, cur};
                           st_next.ev[4*i + EV_DET] = 1'b1;
                           st_next.p[i].step = 2'h0;
                           // Both slopes must fall inside the window; d_up/d_dn wrap if negative.
                           if (d_up >= SIG_DMIN && d_up <= SIG_DMAX &&
                               d_dn >= SIG_DMIN && d_dn <= SIG_DMAX) begin
                              st_next.p[i].st = ST_CLS;
                           end else begin
                              st_next.p[i].st = ST_IDLE;
                           end
                        end
                     endcase
                  end else if (tick) begin
                     st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                  end
               end
               ST_CLS: begin
                  if (tick && st_reg.p[i].ms ==
                      ((st_reg.p[i].step == 2'h1) ? T_MARK_MS : T_SETTLE_MS)) begin
                     st_next.p[i].ms = '0;
                     case (st_reg.p[i].step)
                        2'h0: begin
                           st_next.p[i].cls = cur;
                           if (hp) begin
                              st_next.p[i].step = 2'h1;
                           end else begin
                              cls_done = 1'b1;
                           end
                        end
                        2'h1:    st_next.p[i].step = 2'h2;
                        default: begin
                           st_next.p[i].cls = cur;
                           cls_done = 1'b1;
                        end
                     endcase
                  end else if (tick) begin
                     st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                  end
                  if (cls_done) begin
                     st_next.ev[4*i + EV_CLS] = 1'b1;
                     st_next.p[i].st = ST_START;
                     st_next.p[i].step = 2'h0;
                     st_next.p[i].ovl = '0;
                  end
               end
               ST_START: begin
                  // Start-up window: inrush may sit in limit without integrating overload.
                  if (tick) begin
                     if (st_reg.p[i].ms == T_START_MS - 12'h1) begin
                        st_next.p[i].st = ST_ON;
                        st_next.p[i].ms = '0;
                        st_next.p[i].lim_low = st_reg.mode[MODE_SLOPE];
                     end else begin
                        st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                     end
                  end
               end
               ST_ON: begin
                  if (tick) begin
                     // Net rise only when overloaded more than one tick in sixteen.
                     if (ovl) begin
                        st_next.p[i].ovl = st_reg.p[i].ovl + OVL_UP;
                     end else if (st_reg.p[i].ovl != '0) begin
                        st_next.p[i].ovl = st_reg.p[i].ovl - OVL_DN;
                     end
                     if (st_reg.mode[MODE_SLOPE]) begin
                        if (st_reg.p[i].lim_low && st_reg.flg2[i]) begin
                           st_next.p[i].lim_low = 1'b0;
                           st_next.p[i].ms = '0;
                        end else if (st_reg.p[i].ms >= T_DISC_MS - 12'h1) begin
                           st_next.p[i].ms = '0;
                           if (st_reg.p[i].lim_low) begin
                              st_next.p[i].st = ST_IDLE;
                              st_next.ev[4*i + EV_DISC] = 1'b1;
                           end else begin
                              st_next.p[i].lim_low = 1'b1;
                           end
                        end else begin
                           st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                        end
                     end else if (cur < I_DISC) begin
                        if (st_reg.p[i].ms >= T_DISC_MS) begin
                           st_next.p[i].st = ST_IDLE;
                           st_next.p[i].ms = '0;
                           st_next.ev[4*i + EV_DISC] = 1'b1;
                        end else begin
                           st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                        end
                     end else begin
                        st_next.p[i].ms = '0;
                     end
                     if (ovl && st_reg.p[i].ovl + OVL_UP >= OVL_LIMIT) begin
                        st_next.p[i].st = ST_BACKOFF;
                        st_next.p[i].ms = '0;
                        st_next.p[i].lim_low = 1'b0;
                        st_next.ev[4*i + EV_CUT] = 1'b1;
                     end
                  end
               end
               ST_BACKOFF: begin
                  // Re-power only goes through a fresh detection.
                  if (tick) begin
                     if (st_reg.p[i].ms == T_BACKOFF_MS) begin
                        st_next.p[i].st = ST_IDLE;
                        st_next.p[i].ms = gap;
                     end else begin
                        st_next.p[i].ms = st_reg.p[i].ms + 12'h1;
                     end
                  end
               end
               default: st_next.p[i].st = ST_IDLE;
            endcase
         end
      end
   end

   // State register; power-up mode comes from the build-time selection.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
         for (int i = 0; i < NPORT; i++) begin
            st_reg.p[i].st <= ST_IDLE;
         end
         st_reg.mode <= {2'b00, STARTUP_AUTO};
      end else begin
         st_reg <= st_next;
      end
   end

   // Front-end drive decoded from the registered port states.
   always_comb begin
      logic [15:0] lim;
      logic        on;
      lim = '0;
      on = 1'b0;
      reg_rdata = st_reg.rdata;
      for (int i = 0; i < NPORT; i++) begin
         lim = qpse_lim(st_reg.cfg[CFG_LIM0 + i]);
         on = (st_reg.p[i].st == ST_START) || (st_reg.p[i].st == ST_ON);
         port_clamp[i] = st_reg.p[i].clamp != 7'h0;
         port_gate_on[i] = on && !port_clamp[i];
         port_range_hi[i] = st_reg.p[i].range_hi;
         port_fold_ref[i] = on ? (lim >> FOLD_SHIFT) : 16'h0000;
         case (st_reg.p[i].st)
            ST_DET: begin
               port_force[i] = (st_reg.p[i].step == 2'h1) ? FV_8V : FV_4V;
               port_ilim[i] = IL_3MA;
            end
            ST_CLS: begin
               port_force[i] = (st_reg.p[i].step == 2'h1) ? FV_8V : FV_18V;
               port_ilim[i] = IL_60MA;
            end
            ST_START, ST_ON: begin
               port_force[i] = FV_MAIN;
               if (st_reg.p[i].lim_low) begin
                  port_ilim[i] = IL_7P5MA;
               end else begin
                  port_ilim[i] = st_reg.cfg[CFG_LIM0 + i] ? IL_800 : IL_400;
               end
            end
            default: begin
               port_force[i] = FV_OFF;
               port_ilim[i] = IL_OFF;
            end
         endcase
      end
   end

endmodule

// *** tb/qpse_properties.sv ***
// Checker for the four-port power sequencer, watching only its top-level ports.
// Assumes one clock domain and the asynchronous active-high reset of the design.
module qpse_chk (
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             reg_rd,
   input wire logic [31:0]      reg_rdata,
   input wire logic [3:0][15:0] port_cur_raw,
   input wire logic             die_hot,
   input wire logic [3:0][2:0]  port_force,
   input wire logic [3:0][2:0]  port_ilim,
   input wire logic [3:0]       port_gate_on,
   input wire logic [3:0]       port_clamp,
   input wire logic [3:0][15:0] port_fold_ref
);
   timeunit 1ns;
   timeprecision 1ns;
   import qpse_pkg::*;
   logic [6:0] clamp_len_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Length of the present clamp on port 0; it saturates so a long clamp cannot wrap to a short one.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) clamp_len_reg <= 7'h00;
      else if (!port_clamp[0]) clamp_len_reg <= 7'h00;
      else if (clamp_len_reg != 7'h7F) clamp_len_reg <= clamp_len_reg + 7'h01;
   end

   AST_CLAMP_LEN: assert property ($fell(port_clamp[0]) |-> clamp_len_reg >= 7'h64)
      else $error("clamp released too early");
   AST_CLAMP_GATE: assert property (port_clamp[0] |-> !port_gate_on[0])
      else $error("gate driven while clamped");
   // Port 1 runs one-event classification, so an 8 V level there can only be a detection step.
   AST_DET_LIMIT: assert property (port_force[1] inside {FV_4V, FV_8V} |-> port_ilim[1] == IL_3MA)
      else $error("detection limit not 3 mA");
   AST_DET_ORDER: assert property ($rose(port_force[1] == FV_8V) |-> $past(port_force[1]) == FV_4V)
      else $error("8 V step not after 4 V");
   AST_CLS_LIMIT: assert property (port_force[2] == FV_18V |-> port_ilim[2] == IL_60MA)
      else $error("class probe limit not 60 mA");
   AST_THERMAL: assert property (die_hot [*4] |-> port_gate_on == 4'h0 && port_force == '0)
      else $error("ports active while die hot");
   AST_FOLD: assert property (port_gate_on[1] && port_ilim[1] == IL_800 |->
      port_fold_ref[1] == (I_LIM_800 >> FOLD_SHIFT)) else $error("foldback not scaled");
   AST_SHORT: assert property ((port_gate_on[3] && port_ilim[3] == IL_400 &&
      port_cur_raw[3] > 16'h1388) [*3] |-> ##[1:3] !port_gate_on[3]) else $error("short not cut");
   AST_GATE_MAIN: assert property (port_gate_on[0] |-> port_force[0] == FV_MAIN)
      else $error("gate on outside power state");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
endmodule

bind qpse_seq qpse_chk qpse_chk_inst (.clk, .sys_rst, .reg_rd, .reg_rdata, .port_cur_raw, .die_hot,
   .port_force, .port_ilim, .port_gate_on, .port_clamp, .port_fold_ref);

// *** tb/qpse_pd_model.sv ***
// Powered-device model for the four cable ports of the sequencer.
// Assumes the forced-voltage codes of the sequencer and a load current per port chosen by the bench.
module qpse_pd_model #(
   parameter logic [15:0] CLS_CUR = 16'h00C8
) (
   input  wire logic [3:0][2:0]  port_force,
   input  wire logic [3:0][15:0] load,
   output logic      [3:0][15:0] port_cur_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   import qpse_pkg::*;

   // A 20 kOhm signature, a fixed class current, and the bench's load once powered; an off port draws nothing.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         case (port_force[p])
            FV_4V:   port_cur_raw[p] = 16'h0010;
            FV_8V:   port_cur_raw[p] = 16'h0012;
            FV_18V:  port_cur_raw[p] = CLS_CUR;
            FV_MAIN: port_cur_raw[p] = load[p];
            default: port_cur_raw[p] = 16'h0000;
         endcase
      end
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the four-port power sequencer with powered-device models on all ports.
// Assumes the register bus answers one cycle after each read strobe and a 10-cycle tick.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import qpse_pkg::*;
   logic             clk;
   logic             sys_rst;
   logic [3:0]       reg_addr;
   logic [31:0]      reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic [31:0]      reg_rdata;
   logic [3:0][15:0] port_cur_raw;
   logic [3:0][15:0] load;
   logic [15:0]      vee_raw;
   logic [3:0]       port_surge;
   logic [3:0]       port_vrise;
   logic [3:0]       port_range_hi;
   logic [3:0]       port_hot;
   logic             die_hot;
   logic [3:0][2:0]  port_force;
   logic [3:0][2:0]  port_ilim;
   logic [3:0]       port_gate_on;
   logic [3:0]       port_clamp;
   logic             rd_seen = 1'b0;
   logic [31:0]      exp_q[$];
   int               bad_count = 0;
   int               n_checks = 0;
   int               cyc = 0;

   qpse_seq #(.STARTUP_AUTO(1'b1), .TICK_CYCLES(10)) qpse_seq_inst (.clk, .sys_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .port_cur_raw, .vee_raw, .port_vrise, .port_surge, .port_hot,
      .port_vbad(4'h0), .die_hot, .port_force, .port_ilim, .port_gate_on, .port_clamp, .port_range_hi,
      .port_fold_ref());
   qpse_pd_model qpse_pd_model_inst (.port_force, .load, .port_cur_raw);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Bus cycles start just after an edge; a spare edge keeps a strobe from being set twice in one step.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_gate(input logic [3:0] m);
      for (int i = 0; i < 6000 && port_gate_on !== m; i++) @(posedge clk);
      check(32'(port_gate_on), 32'(m));
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Read answers are compared mid-cycle after the strobe, oldest note first; a hang ends the run.
   always @(negedge clk) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
   end
   always @(posedge clk) begin
      rd_seen <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         final_report();
      end
   end

   // Bring all ports up, read results back, inject surge, short, port heat and die heat, then slope mode.
   initial begin
      void'($urandom(96045));
      {reg_addr, reg_wdata, reg_wr, reg_rd, port_surge, port_vrise, port_hot, die_hot} = '0;
      vee_raw = 16'($urandom);
      for (int p = 0; p < 4; p++) load[p] = 16'h0100 + 16'($urandom_range(0, 2047));
      sys_rst = 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(REG_MODE, 32'h0000_0001);
      rd(REG_CFG, 32'h0000_0000);
      rd(4'hD, 32'h0000_0000);
      wr(REG_CFG, 32'h0000_0021);
      wait_gate(4'hF);
      check(32'(port_ilim[0]), 32'(IL_400));
      check(32'(port_ilim[1]), 32'(IL_800));
      rd(REG_STATUS, 32'h0000_06DB);
      rd(REG_EVENT, 32'h0000_3333);
      for (int p = 0; p < 4; p++) rd(REG_CUR0 + 4'(p), 32'(load[p]));
      for (int p = 0; p < 4; p++) rd(REG_CLS0 + 4'(p), 32'h0000_00C8);
      rd(REG_VEE, 32'(vee_raw));
      for (int p = 0; p < 4; p++) check(32'(port_range_hi[p]), 32'(load[p] >= RANGE_UP));
      port_surge <= 4'h1;
      @(posedge clk);
      port_surge <= 4'h0;
      repeat (50) @(posedge clk);
      check(32'({port_clamp, port_gate_on}), 32'h0000_001E);
      repeat (80) @(posedge clk);
      check(32'(port_gate_on), 32'h0000_000F);
      load[3] <= 16'h1400;
      port_hot <= 4'h4;
      repeat (10) @(posedge clk);
      check(32'(port_gate_on), 32'h0000_0003);
      rd(REG_EVENT, 32'h0000_7733);
      die_hot <= 1'b1;
      repeat (6) @(posedge clk);
      check(32'(port_force), 32'h0000_0000);
      rd(REG_STATUS, 32'h0001_0000);
      rd(REG_EVENT, 32'h0001_7733);
      wr(REG_EVENT, 32'h0001_7733);
      rd(REG_EVENT, 32'h0001_0000);
      // Slope mode: port 1 overloaded, port 2 sees one voltage rise, ports 0 and 3 never do.
      {die_hot, port_hot} <= '0;
      load[1] <= 16'h2000;
      load[3] <= 16'h0100;
      wr(REG_MODE, 32'h0000_0003);
      wait_gate(4'hF);
      repeat (400) @(posedge clk);
      check(32'(port_ilim[2]), 32'(IL_7P5MA));
      port_vrise <= 4'h4;
      repeat (12) @(posedge clk);
      port_vrise <= 4'h0;
      repeat (3) @(posedge clk);
      check(32'(port_ilim[2]), 32'(IL_400));
      wait_gate(4'h4);
      rd(REG_EVENT, 32'h0001_B37B);
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule
